//--- rtl/sarc_core.v
// Alert response, conversion control and general call reset of the sensor
`timescale 1ns/1ps
`include "sarc_defines.vh"

module sarc_core (
   input  wire       i_sys_clk,        // System clock, 100 MHz
   input  wire       i_sys_rst,        // Synchronous reset, active high
   input  wire       i_scl,            // Serial clock pin
   input  wire       i_sda,            // Serial data pin, input side
   output wire       o_sda,            // Serial data drive value (always 0)
   output wire       o_sda_oe_n,       // Serial data enable, low drives low
   input  wire [6:0] i_slave_addr,     // Own slave address
   input  wire [7:0] i_cfg,            // Configuration register 1 value
   input  wire       i_cfg_we,         // Write strobe for configuration
   input  wire       i_open_fault,     // Open sensor comparator, async
   input  wire       i_supply_ok,      // Supply valid comparator, async
   input  wire       i_hi_viol,        // High limit violation, same domain
   input  wire       i_lo_viol,        // Low limit violation, same domain
   input  wire       i_thermal_limit_output_viol,     // Thermal limit violation
   input  wire       i_status_clr,     // Status read clears status
   input  wire [7:0] i_adc_temp,       // Fresh conversion result
   output reg  [7:0] o_cfg,            // Configuration readback
   output reg  [7:0] o_status,         // Status register
   output reg  [7:0] o_temp,           // Reported temperature
   output reg        o_conv_busy,      // Conversion in progress
   output reg        o_conv_start,     // Conversion start pulse
   output wire       o_alert_n,        // Early warning output, active low
   output wire       o_thermal_limit_output_n // Thermal alarm, active low
);

   //----------------------------------------------------------------
   // Input synchronisers
   //----------------------------------------------------------------
   reg  [3:0] sync1;                   // First stage, read only by sync2
   reg  [3:0] sync2;                   // Second stage
   reg        scl_d;                   // Delayed scl
   reg        sda_d;                   // Delayed sda
   wire       scl_s = sync2[0];
   wire       sda_s = sync2[1];
   wire       open_s = sync2[2];
   wire       sup_s = sync2[3];

   // Two flip-flops on the scl, sda, open fault and supply inputs
   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         // Idle levels: bus lines high, no open fault, supply not yet proven
         // valid, so no false fault and no early start follow reset
         sync1 <= 4'h3;
         sync2 <= 4'h3;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         sync1 <= {i_supply_ok, i_open_fault, i_sda, i_scl};
         sync2 <= sync1;
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   wire scl_rise = scl_s & ~scl_d;     // Sample point
   wire scl_fall = ~scl_s & scl_d;     // Drive change point
   wire start_c  = scl_s & sda_d & ~sda_s;
   wire stop_c   = scl_s & ~sda_d & sda_s;

   //----------------------------------------------------------------
   // Serial slave state machine
   //----------------------------------------------------------------
   localparam ST_IDLE = 3'h0;          // Wait for start
   localparam ST_ADDR = 3'h1;          // Receive address byte
   localparam ST_ACK  = 3'h2;          // Drive acknowledge
   localparam ST_GC2  = 3'h3;          // Receive general call byte
   localparam ST_TX   = 3'h4;          // Send alert response address
   localparam ST_TACK = 3'h5;          // Master acknowledge of address
   localparam ST_WAIT = 3'h6;          // Ignore till stop

   reg  [2:0] state;                   // Current state
   reg  [3:0] bitcnt;                  // Bit counter
   reg  [7:0] shreg;                   // Receive shift register
   reg  [7:0] txbyte;                  // Response byte
   reg        ack_drv;                 // Driving acknowledge low
   reg        tx_drv;                  // Driving data low
   reg        is_gc;                   // Address was general call
   reg        is_ara;                  // Address was alert response
   reg        ara_won;                 // Full address sent without loss
   reg        gc_reset;                // Software reset pulse
   reg        alert_release;           // Release pulse after won response
   reg        alert_act;               // Alert latched active
   reg        alert_hi;                // Cause was a high limit
   reg        thermal_limit_output_act;               // Thermal alarm active

   wire alert_mode = ~o_cfg[`SARC_CFG_ALTH_BIT];
   wire alert_vis  = alert_act & alert_mode & ~o_cfg[`SARC_CFG_MASK_BIT];

   assign o_sda      = 1'b0;
   assign o_sda_oe_n = ~(ack_drv | tx_drv);
   assign o_alert_n  = ~alert_vis;
   assign o_thermal_limit_output_n = ~thermal_limit_output_act;

   // Bus protocol handling
   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         state <= ST_IDLE;
         bitcnt <= 4'h0;
         shreg <= 8'h00;
         txbyte <= 8'h00;
         ack_drv <= 1'b0;
         tx_drv <= 1'b0;
         is_gc <= 1'b0;
         is_ara <= 1'b0;
         ara_won <= 1'b0;
         gc_reset <= 1'b0;
         alert_release <= 1'b0;
      end else begin
         gc_reset <= 1'b0;
         alert_release <= 1'b0;
         if (start_c) begin
            // Start or repeated start restarts address reception
            state <= ST_ADDR;
            bitcnt <= 4'h0;
            ack_drv <= 1'b0;
            tx_drv <= 1'b0;
         end else if (stop_c) begin
            // Won alert response completes at stop
            if (is_ara && ara_won) begin
               alert_release <= 1'b1;
            end
            state <= ST_IDLE;
            ack_drv <= 1'b0;
            tx_drv <= 1'b0;
            is_ara <= 1'b0;
            ara_won <= 1'b0;
         end else begin
            case (state)
               ST_ADDR, ST_GC2: begin
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], sda_s};
                     bitcnt <= bitcnt + 4'h1;
                  end else if (scl_fall && bitcnt == 4'h8) begin
                     bitcnt <= 4'h0;
                     if (state == ST_GC2) begin
                        // Second byte accepted; only reset code acts
                        ack_drv <= 1'b1;
                        state <= ST_ACK;
                        if (shreg == `SARC_GCALL_RESET) begin
                           gc_reset <= 1'b1;
                        end
                     end else if (shreg == {`SARC_GCALL_ADDR, 1'b0}) begin
                        ack_drv <= 1'b1;
                        is_gc <= 1'b1;
                        state <= ST_ACK;
                     end else if (shreg == {`SARC_ARA_ADDR, 1'b1} && alert_vis) begin
                        ack_drv <= 1'b1;
                        is_ara <= 1'b1;
                        is_gc <= 1'b0;
                        ara_won <= 1'b1;
                        txbyte <= {i_slave_addr, alert_hi};
                        state <= ST_ACK;
                     end else begin
                        state <= ST_WAIT;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     ack_drv <= 1'b0;
                     if (is_ara) begin
                        tx_drv <= ~txbyte[7];
                        state <= ST_TX;
                     end else if (is_gc && bitcnt == 4'h0) begin
                        is_gc <= 1'b0;
                        state <= ST_GC2;
                     end else begin
                        state <= ST_WAIT;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_rise) begin
                     // Arbitration: released high but seen low means lost
                     if (!tx_drv && !sda_s) begin
                        ara_won <= 1'b0;
                        state <= ST_WAIT;
                     end
                     bitcnt <= bitcnt + 4'h1;
                  end else if (scl_fall) begin
                     if (bitcnt == 4'h8) begin
                        tx_drv <= 1'b0;
                        state <= ST_TACK;
                     end else begin
                        tx_drv <= ~txbyte[3'h7 - bitcnt[2:0]];
                     end
                  end
               end
               ST_TACK: begin
                  if (scl_fall) begin
                     state <= ST_WAIT;
                  end
               end
               ST_WAIT: begin
                  tx_drv <= 1'b0;
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   //----------------------------------------------------------------
   // Configuration, status and alarms
   //----------------------------------------------------------------
   // Config register with general call restore
   always @(posedge i_sys_clk) begin
      if (i_sys_rst || gc_reset) begin
         o_cfg <= `SARC_CFG_RESET;
      end else if (i_cfg_we) begin
         o_cfg <= i_cfg;
      end
   end

   // Alert latch, status flag; set wins over clear
   always @(posedge i_sys_clk) begin
      if (i_sys_rst || gc_reset) begin
         alert_act <= 1'b0;
         alert_hi <= 1'b0;
         thermal_limit_output_act <= 1'b0;
         o_status <= 8'h00;
      end else begin
         thermal_limit_output_act <= i_thermal_limit_output_viol;
         if (i_status_clr) begin
            o_status <= 8'h00;
         end
         if (open_s && o_conv_busy) begin
            o_status[`SARC_STAT_OPEN_BIT] <= 1'b1;
         end
         if ((open_s && o_conv_busy) || i_hi_viol || i_lo_viol) begin
            alert_act <= 1'b1;
            alert_hi <= i_hi_viol;
         end else if (alert_release) begin
            alert_act <= 1'b0;
         end
      end
   end

   //----------------------------------------------------------------
   // Conversion sequencer
   //----------------------------------------------------------------
   reg        conv_bad;                // Fault seen this conversion
   reg [15:0] conv_cnt;                // Conversion timer

   // Back-to-back conversions, gated by shutdown and supply
   always @(posedge i_sys_clk) begin
      o_conv_start <= 1'b0;
      if (i_sys_rst || gc_reset) begin
         o_conv_busy <= 1'b0;
         conv_cnt <= 16'h0000;
         conv_bad <= 1'b0;
         o_temp <= 8'h00;
      end else if (o_cfg[`SARC_CFG_SD_BIT]) begin
         o_conv_busy <= 1'b0;
         conv_cnt <= 16'h0000;
      end else if (!o_conv_busy) begin
         if (sup_s) begin
            o_conv_busy <= 1'b1;
            o_conv_start <= 1'b1;
            conv_cnt <= 16'h0000;
            conv_bad <= 1'b0;
         end
      end else begin
         if (open_s || !sup_s) begin
            conv_bad <= 1'b1;
         end
         if (conv_cnt == `SARC_CONV_CYC - 1) begin
            o_conv_busy <= 1'b0;
            if (!conv_bad && !open_s && sup_s) begin
               o_temp <= i_adc_temp;
            end
         end else begin
            conv_cnt <= conv_cnt + 16'h0001;
         end
      end
   end

endmodule // sarc_core

//--- rtl/sarc_defines.vh
// Constants for the sensor alert and reset control block
`ifndef SARC_DEFINES_VH
`define SARC_DEFINES_VH
`define SARC_ARA_ADDR      7'h0c
`define SARC_GCALL_ADDR    7'h00
`define SARC_GCALL_RESET   8'h06
`define SARC_STAT_OPEN_BIT 2
`define SARC_CFG_MASK_BIT  7
`define SARC_CFG_SD_BIT    6
`define SARC_CFG_ALTH_BIT  5
`define SARC_CFG_RESET     8'h00
`define SARC_CONV_NS       1000
`define SARC_CLK_NS        10
`define SARC_CONV_CYC      (`SARC_CONV_NS / `SARC_CLK_NS)
`endif

//--- testbench/sarc_core_sva.sv
// Assertion checker for the sensor alert and reset control block
`timescale 1ns/1ps
module sarc_core_sva (
   input logic       i_sys_clk,    // System clock
   input logic       i_sys_rst,    // Synchronous reset
   input logic       i_open_fault, // Open sensor level
   input logic       i_supply_ok,  // Supply valid level
   input logic [7:0] o_cfg,        // Configuration readback
   input logic [7:0] o_status,     // Status register
   input logic [7:0] o_temp,       // Reported temperature
   input logic       o_conv_busy,  // Conversion in progress
   input logic       o_conv_start, // Conversion start pulse
   input logic       o_alert_n     // Early warning, active low
);
   // ----------------------------------------
   // Clocking, reset and properties
   // ----------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   a_mask_idle: assert property (
      o_cfg[7] && $past(o_cfg[7]) |-> o_alert_n) else $error("alert active while masked");
   a_sd_stopped: assert property (
      o_cfg[6] && $past(o_cfg[6]) |-> !o_conv_busy && !o_conv_start)
      else $error("conversion running in shutdown");
   a_start_busy: assert property (
      o_conv_start |-> ##[0:1] o_conv_busy) else $error("start without busy");
   a_run_on: assert property (
      $fell(o_conv_busy) && !o_cfg[6] && i_supply_ok && $past(i_supply_ok, 4) && !i_open_fault
      |-> ##[0:8] o_conv_start) else $error("conversions not back to back");
   a_supply_nostart: assert property (
      (!i_supply_ok) [*5] |-> !o_conv_start) else $error("start with supply invalid");
   a_supply_hold: assert property (
      (!i_supply_ok) [*5] |-> $stable(o_temp)) else $error("result moved, supply invalid");
   a_open_flag: assert property (
      (i_open_fault && o_conv_busy) [*4] |-> ##[0:6] o_status[2])
      else $error("open flag not set");
   a_open_alert: assert property (
      o_status[2] && !o_cfg[7] && !o_cfg[5] |-> ##[0:2] !o_alert_n)
      else $error("open fault without alert");
endmodule // sarc_core_sva

bind sarc_core sarc_core_sva sarc_core_sva_inst (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
   .i_open_fault(i_open_fault), .i_supply_ok(i_supply_ok), .o_cfg(o_cfg), .o_status(o_status),
   .o_temp(o_temp), .o_conv_busy(o_conv_busy), .o_conv_start(o_conv_start), .o_alert_n(o_alert_n));

//--- testbench/sarc_host.sv
// Behavioural two-wire host master on the far side of the block
`timescale 1ns/1ps
module sarc_host (
   output logic o_scl,     // Serial clock, stands high between frames
   output logic o_sda_low, // Pulls serial data low when set
   input  logic i_sda      // Resolved serial data line
);
   localparam int HALF = 80; // Half of the 160 ns bus clock period
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   // One bit slot: data set while clock low, sampled mid high phase
   task automatic bit_slot(input logic b, output logic s);
      o_sda_low = ~b;
      #HALF o_scl = 1'b1;
      #(HALF/2) s = i_sda;
      #(HALF/2) o_scl = 1'b0;
   endtask
   // Start: data falls while the clock is high
   task automatic start_cond();
      #HALF o_sda_low = 1'b1;
      #HALF o_scl = 1'b0;
   endtask
   // Stop: data rises while the clock is high, then the bus rests
   task automatic stop_cond();
      o_sda_low = 1'b1;
      #HALF o_scl = 1'b1;
      #HALF o_sda_low = 1'b0;
      #HALF;
   endtask
   // Byte slot, most significant bit first, then the acknowledge slot
   task automatic xfer(input logic [7:0] tx, input logic ack_tx,
                       output logic [7:0] rx, output logic ack_rx);
      for (int i = 7; i >= 0; i--)
         bit_slot(tx[i], rx[i]);
      bit_slot(ack_tx, ack_rx);
   endtask
endmodule // sarc_host

//--- testbench/sensor_alert_reset_control_bench.sv
// Self-checking bench for the sensor alert and reset control block
`timescale 1ns/1ps
`include "sarc_defines.vh"
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin \
   miscompares++; $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module sensor_alert_reset_control_bench;
   logic       clk, rst, cfg_we, open_flt, sup_ok, hi_v, lo_v, th_v, rival_low; // Stimulus
   logic [7:0] cfg, adc, cfg_q, stat, temp, rx;                              // Data values
   logic       busy, cstart, alert_n, thermal_limit_output_n, oe_n, sda_o, scl, host_low, ack; // Observed
   int         starts, miscompares, total_checks;                            // Counters
   wire        sda_line = ~host_low & ~rival_low & (oe_n | sda_o);           // Pulled-up line
   sarc_core sarc_core_inst (.i_sys_clk(clk), .i_sys_rst(rst), .i_scl(scl), .i_sda(sda_line),
      .o_sda(sda_o), .o_sda_oe_n(oe_n), .i_slave_addr(7'h4c), .i_cfg(cfg), .i_cfg_we(cfg_we),
      .i_open_fault(open_flt), .i_supply_ok(sup_ok), .i_hi_viol(hi_v), .i_lo_viol(lo_v),
      .i_thermal_limit_output_viol(th_v), .i_status_clr(1'b0), .i_adc_temp(adc), .o_cfg(cfg_q),
      .o_status(stat), .o_temp(temp), .o_conv_busy(busy), .o_conv_start(cstart),
      .o_alert_n(alert_n), .o_thermal_limit_output_n(thermal_limit_output_n));
   sarc_host sarc_host_inst (.o_scl(scl), .o_sda_low(host_low), .i_sda(sda_line));
   // ----------------------------------------
   // Clock, helpers and bus tasks
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Count start pulses over a span
   task automatic cnt(input int n);
      starts = 0;
      repeat (n) begin
         @(negedge clk);
         starts += cstart;
      end
   endtask
   task automatic wr_cfg(input logic [7:0] v);
      cfg = v;
      cfg_we = 1'b1;
      tick(1);
      cfg_we = 1'b0;
   endtask
   // Short limit violation of the chosen direction
   task automatic cause(input logic h, input logic l);
      hi_v = h;
      lo_v = l;
      tick(5);
      {hi_v, lo_v} = 2'b00;
      tick(5);
   endtask
   // Alert response read, optionally with a rival pulling data low
   task automatic ara(input logic riv, input logic ack_e, input logic [7:0] exp);
      sarc_host_inst.start_cond();
      sarc_host_inst.xfer(8'h19, 1'b1, rx, ack);
      `CHK("ara ack", ack_e, ack)
      if (ack === 1'b0) begin
         rival_low = riv;
         sarc_host_inst.xfer(8'hff, 1'b1, rx, ack);
         rival_low = 1'b0;
         if (!riv) `CHK("ara addr", exp, rx)
      end
      sarc_host_inst.stop_cond();
      tick(10);
   endtask
   task automatic gcall(input logic [7:0] code);
      sarc_host_inst.start_cond();
      sarc_host_inst.xfer(8'h00, 1'b1, rx, ack);
      `CHK("gc ack", 1'b0, ack)
      sarc_host_inst.xfer(code, 1'b1, rx, ack);
      `CHK("gc byte ack", 1'b0, ack)
      sarc_host_inst.stop_cond();
      tick(10);
   endtask
   task automatic done(input string s);
      $display("Test %s finished", s);
   endtask
   task automatic summarize();
      $display("Checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Watchdog well beyond the expected run of about 42 us
   initial begin
      #200us;
      miscompares++;
      summarize();
   end
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      {miscompares, total_checks} = 0;
      // Reset high, supply valid, every other stimulus idle
      {rst, cfg, cfg_we, open_flt, sup_ok, hi_v, lo_v, th_v, rival_low} = 16'h8010;
      adc = 8'h3c;
      tick(17);
      rst = 1'b0;
      tick(4);
      `CHK("cfg", `SARC_CFG_RESET, cfg_q)
      cnt(350);
      `CHK("conv run", 1'b1, starts >= 3)
      `CHK("temp", 8'h3c, temp)
      @(posedge cstart);
      tick(20);
      wr_cfg(8'h40);
      tick(2);
      `CHK("abort", 1'b0, busy)
      cnt(300);
      `CHK("sd idle", 1'b1, starts == 0)
      wr_cfg(8'h00);
      sup_ok = 1'b0;
      adc = 8'h55;
      tick(5);
      cnt(300);
      `CHK("no conv", 1'b1, starts == 0)
      `CHK("temp kept", 8'h3c, temp)
      sup_ok = 1'b1;
      cnt(250);
      `CHK("temp new", 8'h55, temp)
      done("conversion");
      for (int k = 0; k < 2; k++) begin
         cause(k == 0, k == 1);
         `CHK("alert set", 1'b0, alert_n)
         ara(1'b0, 1'b0, {7'h4c, k == 0});
         `CHK("alert freed", 1'b1, alert_n)
      end
      cause(1'b1, 1'b0);
      ara(1'b1, 1'b0, 8'h00);
      `CHK("alert kept", 1'b0, alert_n)
      ara(1'b0, 1'b0, 8'h99);
      done("alert response");
      wr_cfg(8'h80);
      th_v = 1'b1;
      cause(1'b1, 1'b0);
      `CHK("masked", 1'b1, alert_n)
      `CHK("thermal_limit_output", 1'b0, thermal_limit_output_n)
      th_v = 1'b0;
      wr_cfg(8'h20);
      cause(1'b1, 1'b0);
      ara(1'b0, 1'b1, 8'h00);
      gcall(8'h06);
      cnt(120);
      // New sample only for the conversion that the fault spoils
      @(posedge cstart);
      tick(1);
      adc = 8'h77;
      tick(9);
      open_flt = 1'b1;
      tick(30);
      `CHK("open flag", 1'b1, stat[`SARC_STAT_OPEN_BIT])
      `CHK("open alert", 1'b0, alert_n)
      tick(100);
      `CHK("temp on fault", 8'h55, temp)
      open_flt = 1'b0;
      wr_cfg(8'h40);
      gcall(8'h05);
      `CHK("gc other", 8'h40, cfg_q)
      `CHK("gc keep", 1'b0, alert_n)
      gcall(8'h06);
      `CHK("gc cfg", `SARC_CFG_RESET, cfg_q)
      `CHK("gc alert", 1'b1, alert_n)
      `CHK("gc status", 8'h00, stat)
      `CHK("gc temp", 8'h00, temp)
      done("faults and general call");
      summarize();
   end
endmodule // sensor_alert_reset_control_bench
